// *** core/tfmr_defs.svh ***
// register offsets, field positions, reset values and counts of the fan monitor bank
`ifndef TFMR_DEFS_SVH
`define TFMR_DEFS_SVH
`define TFMR_OFS_CFG1      8'h00
`define TFMR_OFS_CFG2      8'h01
`define TFMR_OFS_STAT1     8'h02
`define TFMR_OFS_EXTFRAC   8'h06
`define TFMR_OFS_FANCNT    8'h08
`define TFMR_OFS_LOCVAL    8'h0a
`define TFMR_OFS_REMVAL    8'h0b
`define TFMR_OFS_LOCOFS    8'h0d
`define TFMR_OFS_REMOFS    8'h0e
`define TFMR_OFS_FANLIM    8'h10
`define TFMR_OFS_LOCHI     8'h14
`define TFMR_OFS_LOCLO     8'h15
`define TFMR_OFS_LOCOVH    8'h16
`define TFMR_OFS_REMHI     8'h18
`define TFMR_OFS_REMLO     8'h19
`define TFMR_OFS_REMOVH    8'h1a
`define TFMR_RST_CFG1      8'h90
`define TFMR_RST_CFG2      8'h7f
`define TFMR_RST_STAT1     8'h00
`define TFMR_RST_FANLIM    8'hff
`define TFMR_RST_LOCHI     8'h3c
`define TFMR_RST_LOCLO     8'h00
`define TFMR_RST_LOCOVH    8'h46
`define TFMR_RST_REMHI     8'h50
`define TFMR_RST_REMLO     8'h00
`define TFMR_RST_REMOVH    8'h64
`define TFMR_RST_ZERO      8'h00
`define TFMR_C1_MONITOR    0
`define TFMR_C1_ALERT_EN   1
`define TFMR_C1_SPEED_SEL  2
`define TFMR_C1_DRV_INV    3
`define TFMR_C1_FAULT_EN   4
`define TFMR_C1_MODE_LO    5
`define TFMR_C1_MODE_HI    6
`define TFMR_C1_CTRL_SEL   7
`define TFMR_C2_DRV_EN     0
`define TFMR_C2_TACH_EN    2
`define TFMR_C2_LOC_IE     4
`define TFMR_C2_REM_IE     5
`define TFMR_C2_RESTART    7
`define TFMR_C2_WMASK      8'h75
`define TFMR_ST_ALARM      0
`define TFMR_ST_FANFAIL    1
`define TFMR_ST_REMHI      2
`define TFMR_ST_REMLO      3
`define TFMR_ST_REMOVH     4
`define TFMR_ST_DIODE      5
`define TFMR_ST_LOCHI      6
`define TFMR_ST_LOCLO      7
`define TFMR_ST_LOC_MASK   8'hc0
`define TFMR_ST_REM_MASK   8'h3c
`define TFMR_ST_FAN_MASK   8'h03
`define TFMR_FAULT_RUN     3'd5
`endif

// *** core/tfmr_pkg.sv ***
// types of the fan monitor register bank
package tfmr_pkg;
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [7:0] dat;
  } tfmr_wb_req_s;
  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
    logic [7:0] ext_fraction;
    logic [7:0] fan_count;
  } tfmr_meas_s;
  typedef struct packed {
    logic alarm_speed;
    logic rem_high;
    logic rem_low;
    logic rem_overheat;
    logic loc_high;
    logic loc_low;
  } tfmr_cond_s;
  typedef enum logic [1:0] {
    TFMR_BUS_IDLE = 2'b00,
    TFMR_BUS_ACK  = 2'b01,
    TFMR_BUS_WAIT = 2'b11
  } tfmr_bus_e;
endpackage

// *** core/tfmr_regs.sv ***
// register bank of the two-channel temperature monitor and fan controller
// What this block does
// - config one bit 0 enables monitoring cycles
// - config one bit 1 gates alert output
// - config one bit 2 selects speed source
// - config one bit 3 sets drive polarity
// - config one bit 4 enables fan-failure pin
// - config one bits 6:5 pick auto source
// - config one bit 7 auto or software control
// - config two bit 0 enables drive output
// - config two bit 2 enables tach input
// - config two bit 4 gates local interrupts
// - remote interrupt enable clear on diode fault
// - config two bit 7 restarts, self-clears
// - alarm speed flag does not reassert after read
// - fan failure flag reasserts while failing
// - remote high/low flags reassert while true
// - remote overheat flag stays clear after read
// - diode error set at power-up, read keeps
// - local high/low flags reassert while true
// - tach limit resets to ff, count above fails
// - temperature values read-only upper eight bits
// - temperature limits load documented defaults
// - status read releases alert until next event
// - fan fault after five consecutive failures
`timescale 1ns/1ps
`include "tfmr_defs.svh"
module tfmr_regs (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire tfmr_pkg::tfmr_wb_req_s wb_i,
  output logic [7:0]                wb_dat_o,
  output logic                      wb_ack_o,
  input  wire tfmr_pkg::tfmr_meas_s meas_i,
  input  wire tfmr_pkg::tfmr_cond_s cond_i,
  input  wire logic                 cycle_done_i,
  input  wire logic                 diode_fault_i,
  output logic                      monitor_en_o,
  output logic                      speed_sense_select_o,
  output logic                      drive_invert_o,
  output logic [1:0]                auto_source_o,
  output logic                      control_source_select_o,
  output logic                      drive_en_o,
  output logic                      tach_en_o,
  output logic                      soft_restart_o,
  output logic [7:0]                fan_count_limit_o,
  output logic [7:0]                local_offset_o,
  output logic [7:0]                remote_offset_o,
  output logic                      alert_n_o,
  output logic                      fan_fault_n_o,
  output logic                      fan_fault_oe_o
);
  import tfmr_pkg::*;

  logic [7:0] config_one_r;
  logic [7:0] config_two_r;
  logic [7:0] status_one_r;
  logic [7:0] status_one_nxt;
  logic [7:0] fan_speed_count_r;
  logic [7:0] local_temp_offset_r;
  logic [7:0] remote_temp_offset_r;
  logic [7:0] fan_count_limit_r;
  logic [7:0] local_high_limit_r;
  logic [7:0] local_low_limit_r;
  logic [7:0] local_overheat_limit_r;
  logic [7:0] remote_high_limit_r;
  logic [7:0] remote_low_limit_r;
  logic [7:0] remote_overheat_limit_r;

  logic [2:0] fail_run_r;
  logic       alarm_seen_r;
  logic       overheat_seen_r;
  logic       diode_done_r;
  logic       restart_r;

  logic       bus_rst;
  logic       req;
  logic       wr;
  logic       rd_status;
  logic       cycle;
  logic       fan_fail;
  logic [7:0] rd_dat;
  logic [7:0] ie_mask;
  tfmr_bus_e  bus_r;

  // soft restart acts like reset one cycle after the write
  assign bus_rst   = rst_i | restart_r;
  assign req       = wb_i.cyc & wb_i.stb & (bus_r == TFMR_BUS_IDLE);
  assign wr        = req & wb_i.we;
  assign rd_status = req & ~wb_i.we & (wb_i.adr == `TFMR_OFS_STAT1);
  // monitoring events only count while monitoring runs
  assign cycle     = cycle_done_i & config_one_r[`TFMR_C1_MONITOR];
  // count greater than limit means slow or stalled fan
  assign fan_fail  = config_two_r[`TFMR_C2_TACH_EN] &
                     (fan_speed_count_r > fan_count_limit_r);

  // bus handshake: ack one cycle after the request, then drop
  // wait state stops a held strobe from being taken twice
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_r <= TFMR_BUS_IDLE;
    else
      case (bus_r)
        TFMR_BUS_IDLE: if (wb_i.cyc & wb_i.stb) bus_r <= TFMR_BUS_ACK;
        TFMR_BUS_ACK:  bus_r <= TFMR_BUS_WAIT;
        TFMR_BUS_WAIT: if (!(wb_i.cyc & wb_i.stb)) bus_r <= TFMR_BUS_IDLE;
        default:       bus_r <= TFMR_BUS_IDLE;
      endcase
  end

  // read mux; unmapped offsets read as zero
  always_comb
  begin
    case (wb_i.adr)
      `TFMR_OFS_CFG1:    rd_dat = config_one_r;
      `TFMR_OFS_CFG2:    rd_dat = config_two_r;
      `TFMR_OFS_STAT1:   rd_dat = status_one_r;
      `TFMR_OFS_EXTFRAC: rd_dat = meas_i.ext_fraction;
      `TFMR_OFS_FANCNT:  rd_dat = fan_speed_count_r;
      `TFMR_OFS_LOCVAL:  rd_dat = meas_i.local_temp;
      `TFMR_OFS_REMVAL:  rd_dat = meas_i.remote_temp;
      `TFMR_OFS_LOCOFS:  rd_dat = local_temp_offset_r;
      `TFMR_OFS_REMOFS:  rd_dat = remote_temp_offset_r;
      `TFMR_OFS_FANLIM:  rd_dat = fan_count_limit_r;
      `TFMR_OFS_LOCHI:   rd_dat = local_high_limit_r;
      `TFMR_OFS_LOCLO:   rd_dat = local_low_limit_r;
      `TFMR_OFS_LOCOVH:  rd_dat = local_overheat_limit_r;
      `TFMR_OFS_REMHI:   rd_dat = remote_high_limit_r;
      `TFMR_OFS_REMLO:   rd_dat = remote_low_limit_r;
      `TFMR_OFS_REMOVH:  rd_dat = remote_overheat_limit_r;
      default:           rd_dat = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end
    else
    begin
      wb_ack_o <= req;
      if (req & ~wb_i.we)
        wb_dat_o <= rd_dat;
    end
  end

  // self-clearing restart pulse; it clears with everything else
  // bus handshake is not restarted, so the write is still answered
  always_ff @(posedge clk_i)
  begin
    if (rst_i | restart_r)
      restart_r <= 1'b0;
    else
      restart_r <= wr & (wb_i.adr == `TFMR_OFS_CFG2) & wb_i.dat[`TFMR_C2_RESTART];
  end

  // config one is fully writable
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
      config_one_r <= `TFMR_RST_CFG1;
    else if (wr & (wb_i.adr == `TFMR_OFS_CFG1))
      config_one_r <= wb_i.dat;
  end

  // remote enable power-up value follows the diode test
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
      config_two_r <= `TFMR_RST_CFG2;
    else if (wr & (wb_i.adr == `TFMR_OFS_CFG2))
      config_two_r <= (wb_i.dat & `TFMR_C2_WMASK) | (config_two_r & ~`TFMR_C2_WMASK &
                      ~(8'h01 << `TFMR_C2_RESTART));
    else if (!diode_done_r & diode_fault_i)
      config_two_r[`TFMR_C2_REM_IE] <= 1'b0;
  end

  // diode test is sampled once after release of reset
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
      diode_done_r <= 1'b0;
    else
      diode_done_r <= 1'b1;
  end

  // limits and offsets: plain read-write bytes
  // read-only offsets fall through and are ignored
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
    begin
      local_temp_offset_r     <= `TFMR_RST_ZERO;
      remote_temp_offset_r    <= `TFMR_RST_ZERO;
      fan_count_limit_r       <= `TFMR_RST_FANLIM;
      local_high_limit_r      <= `TFMR_RST_LOCHI;
      local_low_limit_r       <= `TFMR_RST_LOCLO;
      local_overheat_limit_r  <= `TFMR_RST_LOCOVH;
      remote_high_limit_r     <= `TFMR_RST_REMHI;
      remote_low_limit_r      <= `TFMR_RST_REMLO;
      remote_overheat_limit_r <= `TFMR_RST_REMOVH;
    end
    else if (wr)
      case (wb_i.adr)
        `TFMR_OFS_LOCOFS: local_temp_offset_r     <= wb_i.dat;
        `TFMR_OFS_REMOFS: remote_temp_offset_r    <= wb_i.dat;
        `TFMR_OFS_FANLIM: fan_count_limit_r       <= wb_i.dat;
        `TFMR_OFS_LOCHI:  local_high_limit_r      <= wb_i.dat;
        `TFMR_OFS_LOCLO:  local_low_limit_r       <= wb_i.dat;
        `TFMR_OFS_LOCOVH: local_overheat_limit_r  <= wb_i.dat;
        `TFMR_OFS_REMHI:  remote_high_limit_r     <= wb_i.dat;
        `TFMR_OFS_REMLO:  remote_low_limit_r      <= wb_i.dat;
        `TFMR_OFS_REMOVH: remote_overheat_limit_r <= wb_i.dat;
        default:          ;
      endcase
  end

  // count is loaded by the tach logic each cycle; a host write wins only when idle
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
      fan_speed_count_r <= `TFMR_RST_ZERO;
    else if (cycle & config_two_r[`TFMR_C2_TACH_EN])
      fan_speed_count_r <= meas_i.fan_count;
    else if (wr & (wb_i.adr == `TFMR_OFS_FANCNT))
      fan_speed_count_r <= wb_i.dat;
  end

  // once-only flags remember they were read while their condition lasts
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
    begin
      alarm_seen_r    <= 1'b0;
      overheat_seen_r <= 1'b0;
    end
    else
    begin
      if (cycle & ~cond_i.alarm_speed)
        alarm_seen_r <= 1'b0;
      else if (rd_status & status_one_r[`TFMR_ST_ALARM])
        alarm_seen_r <= 1'b1;
      if (cycle & ~cond_i.rem_overheat)
        overheat_seen_r <= 1'b0;
      else if (rd_status & status_one_r[`TFMR_ST_REMOVH])
        overheat_seen_r <= 1'b1;
    end
  end

  // set wins over the read clear in the same cycle, except for the alarm speed and remote overheat flags
  always_comb
  begin
    status_one_nxt = status_one_r;
    if (rd_status)
      status_one_nxt = status_one_r & (8'h01 << `TFMR_ST_DIODE);
    if (cycle)
    begin
      if (cond_i.alarm_speed & ~alarm_seen_r & ~(rd_status & status_one_r[`TFMR_ST_ALARM]))
        status_one_nxt[`TFMR_ST_ALARM] = 1'b1;
      if (fan_fail)
        status_one_nxt[`TFMR_ST_FANFAIL] = 1'b1;
      if (cond_i.rem_high)
        status_one_nxt[`TFMR_ST_REMHI] = 1'b1;
      if (cond_i.rem_low)
        status_one_nxt[`TFMR_ST_REMLO] = 1'b1;
      if (cond_i.rem_overheat & ~overheat_seen_r &
          ~(rd_status & status_one_r[`TFMR_ST_REMOVH]))
        status_one_nxt[`TFMR_ST_REMOVH] = 1'b1;
      if (cond_i.loc_high)
        status_one_nxt[`TFMR_ST_LOCHI] = 1'b1;
      if (cond_i.loc_low)
        status_one_nxt[`TFMR_ST_LOCLO] = 1'b1;
    end
    if (!diode_done_r & diode_fault_i)
      status_one_nxt[`TFMR_ST_DIODE] = 1'b1;
  end

  // status holds between cycles; only reads clear it
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
      status_one_r <= `TFMR_RST_STAT1;
    else
      status_one_r <= status_one_nxt;
  end

  // run of consecutive failing cycles; a passing cycle restarts it
  // saturates at the fault run so the count cannot wrap
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
      fail_run_r <= 3'd0;
    else if (cycle)
    begin
      if (!fan_fail)
        fail_run_r <= 3'd0;
      else if (fail_run_r != `TFMR_FAULT_RUN)
        fail_run_r <= fail_run_r + 3'd1;
    end
  end

  // channel masks for the alert; fan bits always reach the alert
  always_comb
  begin
    ie_mask = `TFMR_ST_FAN_MASK;
    if (config_two_r[`TFMR_C2_LOC_IE])
      ie_mask = ie_mask | `TFMR_ST_LOC_MASK;
    if (config_two_r[`TFMR_C2_REM_IE])
      ie_mask = ie_mask | `TFMR_ST_REM_MASK;
  end

  // alert follows the next status, so a read releases it at once
  // fault pin needs a failing fan now, so recovery releases it
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
    begin
      alert_n_o      <= 1'b1;
      fan_fault_n_o  <= 1'b1;
      fan_fault_oe_o <= 1'b0;
    end
    else
    begin
      alert_n_o <= ~(config_one_r[`TFMR_C1_ALERT_EN] & |(status_one_nxt & ie_mask));
      // open drain: only ever driven low
      fan_fault_n_o  <= 1'b0;
      fan_fault_oe_o <= config_one_r[`TFMR_C1_FAULT_EN] &
                        (fail_run_r == `TFMR_FAULT_RUN) & fan_fail;
    end
  end

  // copies of config fields for the rest of the device
  // one cycle behind the registers, traded for flop outputs
  always_ff @(posedge clk_i)
  begin
    if (bus_rst)
    begin
      monitor_en_o            <= 1'b0;
      speed_sense_select_o    <= 1'b0;
      drive_invert_o          <= 1'b0;
      auto_source_o           <= 2'b00;
      control_source_select_o <= 1'b1;
      drive_en_o              <= 1'b0;
      tach_en_o               <= 1'b0;
      fan_count_limit_o       <= `TFMR_RST_FANLIM;
      local_offset_o          <= `TFMR_RST_ZERO;
      remote_offset_o         <= `TFMR_RST_ZERO;
    end
    else
    begin
      monitor_en_o            <= config_one_r[`TFMR_C1_MONITOR];
      speed_sense_select_o    <= config_one_r[`TFMR_C1_SPEED_SEL];
      drive_invert_o          <= config_one_r[`TFMR_C1_DRV_INV];
      auto_source_o           <= config_one_r[`TFMR_C1_MODE_HI:`TFMR_C1_MODE_LO];
      control_source_select_o <= config_one_r[`TFMR_C1_CTRL_SEL];
      drive_en_o              <= config_two_r[`TFMR_C2_DRV_EN];
      tach_en_o               <= config_two_r[`TFMR_C2_TACH_EN];
      fan_count_limit_o       <= fan_count_limit_r;
      local_offset_o          <= local_temp_offset_r;
      remote_offset_o         <= remote_temp_offset_r;
    end
  end

  // already a flop, so no extra stage
  assign soft_restart_o = restart_r;
endmodule

// *** dv/tb_tfmr_regs.sv ***
// self-checking bench of the fan monitor register bank
`timescale 1ns/1ps
module tb_tfmr_regs;
  import tfmr_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_done = 1'b0;
  logic         diode = 1'b0;
  tfmr_wb_req_s wb;
  tfmr_meas_s   meas = '{8'h2a, 8'h55, 8'hc3, 8'h40};
  tfmr_cond_s   cond = '0;
  logic [7:0]   rdat, lim, lofs, rofs, q;
  logic         ack, mon, sense, inv, ctrl, drv, tach, rstrt, alert_n, ffn, ffoe;
  logic [1:0]   auto_src;
  int           fails = 0;
  int           comparisons = 0;
  logic [15:0]  rv [17] = '{16'h0090, 16'h017f, 16'h0200, 16'h06c3, 16'h0800, 16'h0a2a,
    16'h0b55, 16'h0d00, 16'h0e00, 16'h10ff, 16'h143c, 16'h1500, 16'h1646, 16'h1850,
    16'h1900, 16'h1a64, 16'h0700};
  always #2.5 clk_i = ~clk_i;
  tfmr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .meas_i(meas), .cond_i(cond), .cycle_done_i(cyc_done), .diode_fault_i(diode),
    .monitor_en_o(mon), .speed_sense_select_o(sense), .drive_invert_o(inv),
    .auto_source_o(auto_src), .control_source_select_o(ctrl), .drive_en_o(drv),
    .tach_en_o(tach), .soft_restart_o(rstrt), .fan_count_limit_o(lim),
    .local_offset_o(lofs), .remote_offset_o(rofs), .alert_n_o(alert_n),
    .fan_fault_n_o(ffn), .fan_fault_oe_o(ffoe));
  tfmr_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .wb_o(wb));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    bit ok;
    u_host.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // copies lag the register, so let them settle before looking
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic done();
    @(posedge clk_i);
    cyc_done <= 1'b1;
    @(posedge clk_i);
    cyc_done <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rv[i])
      rd(rv[i][15:8], rv[i][7:0]);
    chk({mon, sense, inv, auto_src, ctrl, drv, tach}, 8'h07);
    chk({alert_n, ffoe, lim[0]}, 8'h05);
    $display("test reset done");
    wr(8'h00, 8'h6e);
    wr(8'h0d, 8'ha5);
    wr(8'h0e, 8'h5a);
    wr(8'h0a, 8'h00);
    wr(8'h01, 8'h00);
    chk({mon, sense, inv, auto_src, ctrl, drv, tach}, 8'h78);
    chk(lofs ^ rofs, 8'hff);
    rd(8'h00, 8'h6e);
    rd(8'h0a, 8'h2a);
    rd(8'h01, 8'h0a);
    wr(8'h01, 8'h35);
    wr(8'h08, 8'h40);
    rd(8'h08, 8'h40);
    $display("test access done");
    cond <= '1;
    done();
    rd(8'h02, 8'h00);
    wr(8'h10, 8'h3f);
    wr(8'h00, 8'h93);
    done();
    chk(alert_n, 8'h00);
    rd(8'h02, 8'hdf);
    chk(alert_n, 8'h01);
    done();
    rd(8'h02, 8'hce);
    wr(8'h00, 8'h91);
    done();
    chk(alert_n, 8'h01);
    rd(8'h02, 8'hce);
    wr(8'h01, 8'h05);
    wr(8'h00, 8'h93);
    wr(8'h10, 8'hff);
    done();
    chk(alert_n, 8'h01);
    rd(8'h02, 8'hcc);
    wr(8'h01, 8'h15);
    done();
    chk(alert_n, 8'h00);
    $display("test status done");
    wr(8'h10, 8'h3f);
    chk(lim, 8'h3f);
    for (int i = 1; i <= 6; i++)
    begin
      done();
      chk({ffn, ffoe}, 8'(i >= 5));
    end
    wr(8'h00, 8'h83);
    chk(ffoe, 8'h00);
    wr(8'h10, 8'hff);
    done();
    chk(ffoe, 8'h00);
    $display("test fault done");
    acc(1'b1, 8'h01, 8'h80);
    repeat (3) @(posedge clk_i);
    rd(8'h00, 8'h90);
    rd(8'h01, 8'h7f);
    rd(8'h10, 8'hff);
    $display("test restart done");
    diode <= 1'b1;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    diode <= 1'b0;
    rd(8'h01, 8'h5f);
    rd(8'h02, 8'h20);
    rd(8'h02, 8'h20);
    $display("test diode done");
    tally_and_finish();
  end
endmodule

// *** dv/tfmr_host.sv ***
// wishbone master model standing in for the management host
`timescale 1ns/1ps
module tfmr_host (
  input  wire logic              clk_i,
  input  wire logic              ack_i,
  input  wire logic [7:0]        dat_i,
  output tfmr_pkg::tfmr_wb_req_s wb_o
);
  import tfmr_pkg::*;
  initial wb_o = '0;
  // request held until ack is sampled; bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d};
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = (ack_i === 1'b1);
    end
    q = dat_i;
    wb_o <= '0;
  endtask
endmodule

// *** dv/tfmr_regs_asserts.sv ***
// port assertions of the fan monitor register bank
`timescale 1ns/1ps
module tfmr_regs_asserts (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire tfmr_pkg::tfmr_wb_req_s wb_i,
  input wire logic [7:0]             wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire tfmr_pkg::tfmr_meas_s   meas_i,
  input wire logic                   cycle_done_i,
  input wire logic                   monitor_en_o,
  input wire logic                   drive_invert_o,
  input wire logic [1:0]             auto_source_o,
  input wire logic                   control_source_select_o,
  input wire logic                   soft_restart_o,
  input wire logic                   alert_n_o,
  input wire logic                   fan_fault_n_o,
  input wire logic                   fan_fault_oe_o
);
  import tfmr_pkg::*;
  logic [2:0] runs_r;
  logic       rd_ack;
  assign rd_ack = wb_ack_o && !wb_i.we;
  // counts every monitoring cycle, so only an upper bound on failing ones
  always_ff @(posedge clk_i)
    if (rst_i || soft_restart_o || fan_fault_oe_o)
      runs_r <= 3'h0;
    else if (cycle_done_i && runs_r != 3'h7)
      runs_r <= runs_r + 3'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_CFG_RESET: assert property ($fell(rst_i) |-> !monitor_en_o && !drive_invert_o
    && auto_source_o == 2'b00 && control_source_select_o)
    else $error("config outputs not at reset values");
  AST_OUT_RESET: assert property ($fell(rst_i) |-> alert_n_o && !fan_fault_oe_o)
    else $error("alert or fault active after reset");
  AST_RESTART_GO: assert property (wb_ack_o && wb_i.we && wb_i.adr == 8'h01 && wb_i.dat[7]
    |-> ##[0:1] soft_restart_o)
    else $error("restart write without restart pulse");
  AST_RESTART_RELOAD: assert property (soft_restart_o |=> !soft_restart_o
    ##[0:2] (control_source_select_o && !monitor_en_o))
    else $error("restart not self clearing or not reloading");
  AST_ALERT_RELEASE: assert property (rd_ack && wb_i.adr == 8'h02 && !$past(cycle_done_i)
    |-> alert_n_o)
    else $error("alert kept after status read");
  AST_ALERT_CAUSE: assert property ($fell(alert_n_o) |-> $past(cycle_done_i)
    || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("alert without event or write");
  AST_FAULT_RUN: assert property ($rose(fan_fault_oe_o) |-> runs_r >= 3'h5)
    else $error("fan fault before five cycles");
  AST_FAULT_LOW: assert property (fan_fault_oe_o |-> !fan_fault_n_o)
    else $error("fan fault not driven low");
  AST_RD_TEMP: assert property (rd_ack && wb_i.adr == 8'h0a
    |-> wb_dat_o == $past(meas_i.local_temp))
    else $error("local temperature read wrong");
  C_STATUS_READ: cover property (rd_ack && wb_i.adr == 8'h02);
  C_FAULT: cover property ($rose(fan_fault_oe_o));
  C_RESTART: cover property (soft_restart_o);
endmodule
bind tfmr_regs tfmr_regs_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_i(meas_i), .cycle_done_i(cycle_done_i),
  .monitor_en_o(monitor_en_o), .drive_invert_o(drive_invert_o), .auto_source_o(auto_source_o),
  .control_source_select_o(control_source_select_o), .soft_restart_o(soft_restart_o),
  .alert_n_o(alert_n_o), .fan_fault_n_o(fan_fault_n_o), .fan_fault_oe_o(fan_fault_oe_o));
